/* core/tbsl_pkg.sv */
// tbsl_pkg: constants and carrier types for the tile boot and security loader
// assumes a single 25 MHz clock domain
package tbsl_pkg;
  localparam int          CLK_MHZ         = 25;
  localparam int          INIT_MAX_US     = 150;
  localparam int          INIT_CYCLES     = INIT_MAX_US * CLK_MHZ;
  localparam int          OTP_SECTORS     = 4;
  localparam int          OTP_ROWS        = 512;
  localparam int          OTP_AW          = 11;
  localparam int          RAM_AW          = 16;
  localparam int          FIFO_DEPTH      = 16;
  localparam logic [31:0] SKIP_CODE       = 32'h0d15ab1e;
  localparam logic [31:0] CRC_POLY        = 32'hedb88320;
  localparam logic [31:0] CRC_PRESET      = 32'hffffffff;
  localparam logic [31:0] SEC_RESET       = 32'h00000000;
  localparam logic [RAM_AW-1:0] RAM_BASE  = 16'h0000;
  localparam logic [OTP_AW-1:0] SEC_ROW   = 11'h000;
  localparam logic [OTP_AW-1:0] OTP_BASE  = 11'h000;
  localparam int          B_JTAG_OFF      = 0;
  localparam int          B_LINK_OFF      = 1;
  localparam int          B_SEC_BOOT      = 5;
  localparam int          B_REDUNDANT     = 7;
  localparam int          B_SECT_LOCK0    = 8;
  localparam int          B_MASTER_LOCK   = 12;
  localparam int          B_JTAG_OTP_OFF  = 13;
  localparam int          B_DEBUG_OFF     = 14;
  localparam int          GP_LO           = 15;
  localparam int          GP_HI           = 21;
  localparam int          UC_LO           = 22;
  localparam int          UC_HI           = 31;
  localparam int          SECT_MSB        = 10;
  localparam int          SECT_LSB        = 9;

  typedef enum logic [8:0] {
    TBSL_IDLE   = 9'h001,
    TBSL_SECRD  = 9'h002,
    TBSL_SECWT  = 9'h004,
    TBSL_LEN    = 9'h008,
    TBSL_PROG   = 9'h010,
    TBSL_CHECK  = 9'h020,
    TBSL_VERIFY = 9'h040,
    TBSL_RUN    = 9'h080,
    TBSL_FAIL   = 9'h100
  } tbsl_state_e;

  typedef struct packed {
    logic              valid;
    logic              from_otp;
    logic [OTP_AW-1:0] addr;
  } tbsl_rd_req_s;

  typedef struct packed {
    logic              valid;
    logic [OTP_AW-1:0] addr;
    logic [31:0]       data;
  } tbsl_prog_req_s;
endpackage : tbsl_pkg

/* core/tbsl_loader.sv */
// tbsl_loader: boot image loader and security gating for one tile
// assumes a byte-wide read stream from flash/otp with one byte per request,
// and a word-wide ram write port that always accepts
`timescale 1ns/100ps

module tbsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             s_valid_in,
  output logic                  s_ready_out,
  input  wire logic [WIDTH-1:0] s_data_in,
  output logic                  m_valid_out,
  input  wire logic             m_ready_in,
  output logic      [WIDTH-1:0] m_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // full once DEPTH entries are held
  assign s_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign m_valid_out = (cnt_reg != '0);
  assign m_data_out  = mem_reg[rd_reg];
  assign push        = s_valid_in && s_ready_out;
  assign pop         = m_valid_out && m_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= s_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tbsl_fifo

module tbsl_loader
  import tbsl_pkg::*;
#(
  parameter int INIT_LIMIT = INIT_CYCLES
) (
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // byte read port toward flash or otp
  output tbsl_rd_req_s           rd_req_out,
  input  wire logic              rd_ready_in,
  input  wire logic              rd_valid_in,
  input  wire logic [7:0]        rd_byte_in,
  // security word row from otp, one word per request
  input  wire logic              sec_valid_in,
  input  wire logic [31:0]       sec_word_in,
  // ram write port
  output logic                   ram_we_out,
  output logic      [RAM_AW-1:0] ram_addr_out,
  output logic      [31:0]       ram_data_out,
  // processor start
  output logic                   run_out,
  output logic      [RAM_AW-1:0] start_pc_out,
  output logic                   boot_otp_out,
  output logic                   boot_fail_out,
  output logic                   boot_started_out,
  output logic      [31:0]       tile_security_config_out,
  // otp programming request from the programming agent
  input  tbsl_prog_req_s         prog_req_in,
  output tbsl_prog_req_s         prog_req_out,
  output logic                   prog_reject_out,
  output logic                   otp_redundant_out,
  // test port and link access requests
  input  wire logic              jtag_state_req_in,
  input  wire logic              jtag_otp_req_in,
  input  wire logic              link_ps_req_in,
  input  wire logic              debug_n_in,
  output logic                   jtag_state_gnt_out,
  output logic                   jtag_otp_gnt_out,
  output logic                   link_ps_gnt_out,
  output logic                   debug_req_out,
  output logic      [9:0]        test_port_user_code_out,
  output logic      [6:0]        sec_gp_out
);
  tbsl_state_e  state_reg;
  logic [31:0]  sec_reg;
  logic [31:0]  crc_reg;
  logic [31:0]  shift_reg;
  logic [1:0]   bcnt_reg;
  logic [31:0]  len_reg;
  logic [31:0]  wcnt_reg;
  logic [RAM_AW-1:0] waddr_reg;
  logic [OTP_AW-1:0] raddr_reg;
  logic [12:0]  init_reg;
  logic [31:0]  sec_meta_reg;
  logic [31:0]  sec_sync_reg;
  logic         sec_vmeta_reg;
  logic         sec_vsync_reg;
  logic         sec_vhold_reg;
  // bytes requested and not yet consumed
  logic [4:0]   cred_reg;
  logic [2:0]   pin_meta_reg;
  logic [2:0]   pin_sync_reg;
  logic         dbg_meta_reg;
  logic         dbg_sync_reg;
  logic         f_valid;
  logic         f_ready;
  logic [7:0]   f_byte;
  logic         s_ready;
  logic [31:0]  word_next;
  logic [31:0]  crc_next;
  logic         inflow;
  logic [1:0]   lock_sel;

  tbsl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .s_valid_in  (rd_valid_in),
    .s_ready_out (s_ready),
    .s_data_in   (rd_byte_in),
    .m_valid_out (f_valid),
    .m_ready_in  (f_ready),
    .m_data_out  (f_byte)
  );

  // bytes assemble lsb first into a word
  assign word_next = {f_byte, shift_reg[31:8]};
  assign inflow    = (state_reg == TBSL_LEN) || (state_reg == TBSL_PROG) ||
                     (state_reg == TBSL_CHECK);
  assign f_ready   = inflow;

  // bytewise reflected crc32
  always_comb begin
    crc_next = crc_reg ^ {24'h000000, f_byte};
    for (int i = 0; i < 8; i++) begin
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ CRC_POLY)
                             : (crc_next >> 1);
    end
  end

  // security row and access request pins from outside pass two flops
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sec_meta_reg  <= '0;
      sec_sync_reg  <= '0;
      sec_vmeta_reg <= 1'b0;
      sec_vsync_reg <= 1'b0;
      sec_vhold_reg <= 1'b0;
      pin_meta_reg  <= '0;
      pin_sync_reg  <= '0;
      dbg_meta_reg  <= 1'b1;
      dbg_sync_reg  <= 1'b1;
    end else begin
      sec_meta_reg  <= sec_word_in;
      sec_sync_reg  <= sec_meta_reg;
      sec_vmeta_reg <= sec_valid_in;
      sec_vsync_reg <= sec_vmeta_reg;
      sec_vhold_reg <= sec_vsync_reg;
      pin_meta_reg  <= {link_ps_req_in, jtag_otp_req_in, jtag_state_req_in};
      pin_sync_reg  <= pin_meta_reg;
      dbg_meta_reg  <= debug_n_in;
      dbg_sync_reg  <= dbg_meta_reg;
    end
  end

  // boot sequencer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= TBSL_IDLE;
      sec_reg   <= SEC_RESET;
      crc_reg   <= CRC_PRESET;
      shift_reg <= '0;
      bcnt_reg  <= '0;
      len_reg   <= '0;
      wcnt_reg  <= '0;
      waddr_reg <= RAM_BASE;
      raddr_reg <= OTP_BASE;
      init_reg  <= '0;
    end else begin
      if (init_reg != 13'(INIT_LIMIT)) begin
        init_reg <= init_reg + 13'h0001;
      end
      if (inflow && f_valid) begin
        shift_reg <= word_next;
        bcnt_reg  <= bcnt_reg + 2'h1;
        if (state_reg != TBSL_CHECK) begin
          crc_reg <= crc_next;
        end
      end
      case (state_reg)
        TBSL_IDLE: begin
          state_reg <= TBSL_SECRD;
        end
        TBSL_SECRD: begin
          state_reg <= TBSL_SECWT;
        end
        TBSL_SECWT: begin
          // a second valid cycle lets every word bit settle before capture
          if (sec_vsync_reg && sec_vhold_reg) begin
            sec_reg   <= sec_sync_reg;
            raddr_reg <= OTP_BASE;
            state_reg <= TBSL_LEN;
          end
        end
        TBSL_LEN: begin
          if (f_valid && bcnt_reg == 2'h3) begin
            len_reg   <= word_next;
            wcnt_reg  <= '0;
            waddr_reg <= RAM_BASE;
            state_reg <= (word_next == '0) ? TBSL_CHECK : TBSL_PROG;
          end
        end
        TBSL_PROG: begin
          if (f_valid && bcnt_reg == 2'h3) begin
            waddr_reg <= waddr_reg + RAM_AW'(1);
            wcnt_reg  <= wcnt_reg + 32'h00000001;
            if (wcnt_reg + 32'h00000001 == len_reg) begin
              state_reg <= TBSL_CHECK;
            end
          end
        end
        TBSL_CHECK: begin
          if (f_valid && bcnt_reg == 2'h3) begin
            state_reg <= TBSL_VERIFY;
          end
        end
        TBSL_VERIFY: begin
          if (shift_reg == SKIP_CODE || shift_reg == ~crc_reg) begin
            state_reg <= TBSL_RUN;
          end else begin
            state_reg <= TBSL_FAIL;
          end
        end
        TBSL_RUN: state_reg <= TBSL_RUN;
        TBSL_FAIL: state_reg <= TBSL_FAIL;
        default: state_reg <= TBSL_IDLE;
      endcase
      if (rd_req_out.valid && rd_ready_in) begin
        raddr_reg <= raddr_reg + OTP_AW'(1);
      end
    end
  end

  // capping outstanding bytes at the fifo depth keeps a slow answer
  // from overrunning the fifo
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cred_reg <= '0;
    end else begin
      cred_reg <= cred_reg + 5'(inflow && rd_req_out.valid && rd_ready_in) -
                  5'(inflow && f_valid);
    end
  end

  // byte requests only while fifo has room
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rd_req_out <= '0;
    end else begin
      rd_req_out.valid    <= (state_reg == TBSL_SECRD) || (inflow && s_ready &&
                             cred_reg != 5'(FIFO_DEPTH) &&
                             !(rd_req_out.valid && rd_ready_in));
      rd_req_out.from_otp <= (state_reg == TBSL_SECRD) ||
                             sec_reg[B_SEC_BOOT];
      rd_req_out.addr     <= (state_reg == TBSL_SECRD) ? SEC_ROW : raddr_reg;
    end
  end

  // ram write and start
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ram_we_out       <= 1'b0;
      ram_addr_out     <= RAM_BASE;
      ram_data_out     <= '0;
      run_out          <= 1'b0;
      start_pc_out     <= RAM_BASE;
      boot_fail_out    <= 1'b0;
      boot_otp_out     <= 1'b0;
      boot_started_out <= 1'b0;
    end else begin
      ram_we_out       <= (state_reg == TBSL_PROG) && f_valid &&
                          bcnt_reg == 2'h3;
      ram_addr_out     <= waddr_reg;
      ram_data_out     <= word_next;
      run_out          <= (state_reg == TBSL_RUN);
      start_pc_out     <= RAM_BASE;
      boot_fail_out    <= (state_reg == TBSL_FAIL);
      boot_otp_out     <= sec_reg[B_SEC_BOOT];
      boot_started_out <= (state_reg != TBSL_IDLE);
    end
  end

  // otp sectors are 512 rows: sector index is the top address bits
  assign lock_sel = prog_req_in.addr[SECT_MSB:SECT_LSB];

  // programming gate and access gating
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prog_req_out       <= '0;
      prog_reject_out    <= 1'b0;
      jtag_state_gnt_out <= 1'b0;
      jtag_otp_gnt_out   <= 1'b0;
      link_ps_gnt_out    <= 1'b0;
      debug_req_out      <= 1'b0;
    end else begin
      prog_req_out.addr  <= prog_req_in.addr;
      prog_req_out.data  <= prog_req_in.data;
      prog_req_out.valid <= prog_req_in.valid && !sec_reg[B_MASTER_LOCK] &&
                            !sec_reg[B_SECT_LOCK0 + lock_sel];
      prog_reject_out    <= prog_req_in.valid && (sec_reg[B_MASTER_LOCK] ||
                            sec_reg[B_SECT_LOCK0 + lock_sel]);
      jtag_state_gnt_out <= pin_sync_reg[0] && !sec_reg[B_JTAG_OFF];
      jtag_otp_gnt_out   <= pin_sync_reg[1] && !sec_reg[B_JTAG_OTP_OFF] &&
                            !sec_reg[B_JTAG_OFF];
      link_ps_gnt_out    <= pin_sync_reg[2] && !sec_reg[B_LINK_OFF];
      debug_req_out      <= !dbg_sync_reg && !sec_reg[B_DEBUG_OFF];
    end
  end

  // security word views
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tile_security_config_out <= SEC_RESET;
      otp_redundant_out        <= 1'b0;
      test_port_user_code_out  <= '0;
      sec_gp_out               <= '0;
    end else begin
      tile_security_config_out <= sec_reg;
      otp_redundant_out        <= sec_reg[B_REDUNDANT];
      test_port_user_code_out  <= sec_reg[UC_HI:UC_LO];
      sec_gp_out               <= sec_reg[GP_HI:GP_LO];
    end
  end
endmodule : tbsl_loader

/* test/tbsl_loader_checker.sv */
// tbsl_loader_checker: port-level timing checks for the boot loader
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
module tbsl_loader_checker
  import tbsl_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rstn_in,
  input wire logic              ram_we_out,
  input wire logic              run_out,
  input wire logic [RAM_AW-1:0] start_pc_out,
  input wire logic              boot_fail_out,
  input wire logic              boot_started_out,
  input wire logic [31:0]       tile_security_config_out,
  input tbsl_prog_req_s         prog_req_in,
  input tbsl_prog_req_s         prog_req_out,
  input wire logic              prog_reject_out,
  input wire logic              jtag_state_gnt_out,
  input wire logic              link_ps_gnt_out,
  input wire logic              debug_req_out,
  input wire logic [9:0]        test_port_user_code_out,
  input wire logic [6:0]        sec_gp_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_pc;
    run_out |-> start_pc_out == RAM_BASE;
  endproperty
  a_pc: assert property (p_pc) else $error("bad start");
  property p_fail;
    boot_fail_out |-> !run_out;
  endproperty
  a_fail: assert property (p_fail) else $error("ran after fail");
  property p_we;
    ram_we_out |=> !ram_we_out ##1 !ram_we_out;
  endproperty
  a_we: assert property (p_we) else $error("word too soon");
  property p_init;
    $rose(rstn_in) |-> ##[0:4] boot_started_out;
  endproperty
  a_init: assert property (p_init) else $error("late boot");
  property p_gp;
    $stable(tile_security_config_out) [*2] |->
      sec_gp_out == tile_security_config_out[GP_HI:GP_LO];
  endproperty
  a_gp: assert property (p_gp) else $error("gp bits");
  property p_uc;
    $stable(tile_security_config_out) [*2] |->
      test_port_user_code_out == tile_security_config_out[UC_HI:UC_LO];
  endproperty
  a_uc: assert property (p_uc) else $error("user code");
  property p_master;
    prog_req_in.valid && tile_security_config_out[B_MASTER_LOCK] |=>
      prog_reject_out && !prog_req_out.valid;
  endproperty
  a_master: assert property (p_master) else $error("master lock");
  property p_sect;
    prog_req_in.valid && tile_security_config_out[B_SECT_LOCK0 +
      prog_req_in.addr[SECT_MSB:SECT_LSB]] |=> prog_reject_out;
  endproperty
  a_sect: assert property (p_sect) else $error("sector lock");
  property p_jtag;
    tile_security_config_out[B_JTAG_OFF] [*4] |-> !jtag_state_gnt_out;
  endproperty
  a_jtag: assert property (p_jtag) else $error("test port open");
  property p_link;
    tile_security_config_out[B_LINK_OFF] [*4] |-> !link_ps_gnt_out;
  endproperty
  a_link: assert property (p_link) else $error("link open");
  property p_dbg;
    tile_security_config_out[B_DEBUG_OFF] [*4] |-> !debug_req_out;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug open");
endmodule : tbsl_loader_checker

bind tbsl_loader tbsl_loader_checker chk_u (.clk_in, .rstn_in, .ram_we_out,
  .run_out, .start_pc_out, .boot_fail_out, .boot_started_out,
  .tile_security_config_out, .prog_req_in, .prog_req_out, .prog_reject_out,
  .jtag_state_gnt_out, .link_ps_gnt_out, .debug_req_out,
  .test_port_user_code_out, .sec_gp_out);

/* test/tbsl_store_model.sv */
// tbsl_store_model: flash and otp byte store with the security row answer
// assumes memories and security word are filled by the bench during reset
`timescale 1ns/100ps
module tbsl_store_model
  import tbsl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        slow_in,
  input  tbsl_rd_req_s     rd_req_in,
  output logic             rd_ready_out,
  output logic             rd_valid_out,
  output logic      [7:0]  rd_byte_out,
  output logic             sec_valid_out,
  output logic      [31:0] sec_word_out
);
  logic [7:0]  flash_mem [0:63];
  logic [7:0]  otp_mem   [0:63];
  logic [31:0] sec_cfg;
  logic        tog_reg;
  // an idle security bus shows the inverse word
  assign sec_word_out = sec_valid_out ? sec_cfg : ~sec_cfg;
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      tog_reg <= 1'b0;
      rd_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      sec_valid_out <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      rd_ready_out <= !slow_in || tog_reg;
      // first request fetches the security row
      if (rd_req_in.valid)
        sec_valid_out <= 1'b1;
      if (rd_req_in.valid && rd_ready_out && sec_valid_out) begin
        rd_valid_out <= 1'b1;
        rd_byte_out <= rd_req_in.from_otp ? otp_mem[rd_req_in.addr[5:0]]
                                          : flash_mem[rd_req_in.addr[5:0]];
      end else begin
        rd_valid_out <= 1'b0;
        rd_byte_out <= ~rd_byte_out;
      end
    end
  end
endmodule : tbsl_store_model

/* test/tbsl_loader_bench.sv */
// tbsl_loader_bench: self-checking bench for the boot and security loader
// assumes the store model on the read side; bench acts as programmer
`timescale 1ns/100ps
module tbsl_loader_bench;
  import tbsl_pkg::*;
  logic clk_in, rstn_in, slow_in, rd_ready_in, rd_valid_in, sec_valid_in;
  logic [7:0] rd_byte_in;
  logic [31:0] sec_word_in, ram_data_out, tile_security_config_out;
  tbsl_rd_req_s rd_req_out;
  tbsl_prog_req_s prog_req_in, prog_req_out;
  logic ram_we_out, run_out, boot_otp_out, boot_fail_out, boot_started_out;
  logic [RAM_AW-1:0] ram_addr_out, start_pc_out;
  logic prog_reject_out, otp_redundant_out, jtag_state_req_in;
  logic jtag_otp_req_in, link_ps_req_in, debug_n_in, jtag_state_gnt_out;
  logic jtag_otp_gnt_out, link_ps_gnt_out, debug_req_out;
  logic [9:0] test_port_user_code_out;
  logic [6:0] sec_gp_out;
  logic [31:0] ram_q [0:15];
  int n_fail, checks, cyc, nwr;
  tbsl_loader dut_u (.clk_in, .rstn_in, .rd_req_out, .rd_ready_in,
    .rd_valid_in, .rd_byte_in, .sec_valid_in, .sec_word_in, .ram_we_out,
    .ram_addr_out, .ram_data_out, .run_out, .start_pc_out, .boot_otp_out,
    .boot_fail_out, .boot_started_out, .tile_security_config_out,
    .prog_req_in, .prog_req_out, .prog_reject_out, .otp_redundant_out,
    .jtag_state_req_in, .jtag_otp_req_in, .link_ps_req_in, .debug_n_in,
    .jtag_state_gnt_out, .jtag_otp_gnt_out, .link_ps_gnt_out,
    .debug_req_out, .test_port_user_code_out, .sec_gp_out);
  tbsl_store_model part_u (.clk_in, .rstn_in, .slow_in,
    .rd_req_in(rd_req_out), .rd_ready_out(rd_ready_in),
    .rd_valid_out(rd_valid_in), .rd_byte_out(rd_byte_in),
    .sec_valid_out(sec_valid_in), .sec_word_out(sec_word_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (ram_we_out === 1'b1) begin
      ram_q[ram_addr_out[3:0]] = ram_data_out;
      nwr = nwr + 1;
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  function automatic logic [31:0] word_of(input int i);
    return 32'h13579bdf ^ (32'h01010101 * 32'(i));
  endfunction : word_of
  // writes a word lsb first into both stores, crc taken over flash copy
  task automatic put32(input int a, input logic [31:0] fw,
                       input logic [31:0] ow, inout logic [31:0] crc);
    for (int k = 0; k < 4; k++) begin
      part_u.flash_mem[a + k] = fw[8 * k +: 8];
      part_u.otp_mem[a + k] = ow[8 * k +: 8];
      crc = crc ^ {24'h000000, fw[8 * k +: 8]};
      for (int j = 0; j < 8; j++)
        crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
    end
  endtask : put32
  // mode 0 good crc, 1 uninverted remainder, 2 skip code
  task automatic boot(input logic [31:0] sec, input int n, input int mode);
    logic [31:0] crc, chk, dum;
    int t;
    crc = CRC_PRESET;
    foreach (ram_q[i]) ram_q[i] = '0;
    @(posedge clk_in);
    rstn_in <= 1'b0;
    part_u.sec_cfg = sec;
    put32(0, 32'(n), 32'(n), crc);
    for (int i = 0; i < n; i++)
      put32(4 + 4 * i, word_of(i), word_of(i), crc);
    chk = (mode == 2) ? SKIP_CODE : (mode == 1) ? crc : ~crc;
    if (sec[B_SEC_BOOT]) put32(4 + 4 * n, ~chk, chk, dum);
    else put32(4 + 4 * n, chk, ~chk, dum);
    repeat (6) @(negedge clk_in);
    check(run_out, 1'b0);
    check(tile_security_config_out, SEC_RESET);
    @(posedge clk_in);
    nwr = 0;
    rstn_in <= 1'b1;
    t = 0;
    while (run_out !== 1'b1 && boot_fail_out !== 1'b1 && t < 3000) begin
      @(negedge clk_in);
      t = t + 1;
    end
    repeat (3) @(negedge clk_in);
    check(tile_security_config_out, sec);
    check(boot_otp_out, sec[B_SEC_BOOT]);
    check(run_out, mode != 1);
    check(boot_fail_out, mode == 1);
    check(nwr, n);
    check(start_pc_out, RAM_BASE);
    for (int i = 0; i < n; i++)
      check(ram_q[i], word_of(i));
  endtask : boot
  task automatic t_fields(input logic [31:0] s);
    check(sec_gp_out, s[GP_HI:GP_LO]);
    check(test_port_user_code_out, s[UC_HI:UC_LO]);
    check(otp_redundant_out, s[B_REDUNDANT]);
  endtask : t_fields
  task automatic t_grant(input logic [31:0] s);
    @(posedge clk_in);
    jtag_state_req_in <= 1'b1;
    jtag_otp_req_in <= 1'b1;
    link_ps_req_in <= 1'b1;
    debug_n_in <= 1'b0;
    repeat (5) @(negedge clk_in);
    check(jtag_state_gnt_out, !s[B_JTAG_OFF]);
    check(jtag_otp_gnt_out, !(s[B_JTAG_OTP_OFF] || s[B_JTAG_OFF]));
    check(link_ps_gnt_out, !s[B_LINK_OFF]);
    check(debug_req_out, !s[B_DEBUG_OFF]);
    @(posedge clk_in);
    jtag_state_req_in <= 1'b0;
    jtag_otp_req_in <= 1'b0;
    link_ps_req_in <= 1'b0;
    debug_n_in <= 1'b1;
    repeat (5) @(negedge clk_in);
    check({jtag_state_gnt_out, jtag_otp_gnt_out, link_ps_gnt_out,
           debug_req_out}, 4'h0);
  endtask : t_grant
  task automatic t_prog(input logic [31:0] s);
    logic lock;
    for (int k = 0; k < 4; k++) begin
      lock = s[B_MASTER_LOCK] || s[B_SECT_LOCK0 + k];
      @(posedge clk_in);
      prog_req_in <= '{1'b1, {2'(k), 9'h0a5}, 32'hc0de0000 + 32'(k)};
      @(posedge clk_in);
      prog_req_in.valid <= 1'b0;
      @(negedge clk_in);
      check(prog_reject_out, lock);
      check(prog_req_out.valid, !lock);
      if (!lock)
        check(prog_req_out.data, 32'hc0de0000 + 32'(k));
    end
  endtask : t_prog
  initial begin
    rstn_in = 1'b0;
    slow_in = 1'b0;
    prog_req_in = '0;
    jtag_state_req_in = 1'b0;
    jtag_otp_req_in = 1'b0;
    link_ps_req_in = 1'b0;
    debug_n_in = 1'b1;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    nwr = 0;
    boot(32'h6a5a8080, 3, 0);
    t_fields(32'h6a5a8080);
    t_grant(32'h6a5a8080);
    t_prog(32'h6a5a8080);
    slow_in <= 1'b1;
    boot(32'h00000000, 2, 1);
    slow_in <= 1'b0;
    boot(32'h00002a20, 0, 2);
    t_grant(32'h00002a20);
    t_prog(32'h00002a20);
    boot(32'h00007f23, 14, 2);
    t_fields(32'h00007f23);
    t_grant(32'h00007f23);
    t_prog(32'h00007f23);
    print_verdict();
  end
endmodule : tbsl_loader_bench
